// ---- inc/host_port_pkg.sv ----
// constants for the parallel host port front end
package host_port_pkg;
  // wishbone register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00; // interrupt config, trigger
  localparam logic [7:0] REG_STATUS = 8'h04; // straps and captures
  localparam logic [7:0] REG_WDATA  = 8'h08; // last data word, read only
  // control register fields
  localparam int CTRL_POL_BIT  = 0;          // 1: active high interrupt
  localparam int CTRL_EDGE_BIT = 1;          // 1: pulse, 0: held level
  localparam int CTRL_REQ_BIT  = 2;          // 1: raise event (self-clear)
  localparam int CTRL_ACK_BIT  = 3;          // 1: drop held level
  // status register fields
  localparam int STAT_STYLE_BIT = 0;         // captured strobe style
  localparam int STAT_PHASE_BIT = 1;         // captured address phase
  localparam int STAT_AVAL_BIT  = 2;         // address captured
  localparam int STAT_DVAL_BIT  = 3;         // data captured
  localparam int STAT_ADDR_LSB  = 8;         // address field lsb
  // reset values
  localparam logic [1:0] CTRL_RST = 2'h0;    // active low, level mode
  localparam logic [7:0] BYTE_RST = 8'h00;   // cleared byte
  // strap capture delay after reset release, in cycles
  localparam logic [1:0] STRAP_WAIT = 2'h3;  // past the two sync stages
  // interrupt pulse width in cycles
  localparam logic [1:0] PULSE_LEN  = 2'h2;  // pulse mode width
endpackage

// ---- hdl/host_bus_strobe_address_decode.sv ----
// parallel host port strobe and address decode with interrupt pin
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module host_bus_strobe_address_decode (
  input  wire logic        clk_sys_i,          // 100 mhz system clock
  input  wire logic        arst_n_i,           // async reset, active low
  input  wire logic        clk_en_i,           // freezes all state when low
  input  wire logic        strobe_style_select_i, // strap: strobe style
  input  wire logic        address_phase_select_i,// strap: address phase
  input  wire logic        cs_n_i,             // chip select pin
  input  wire logic        strobe_a_i,         // direction or read strobe
  input  wire logic        strobe_b_i,         // data or write strobe pin
  input  wire logic        addr_data_qualifier_i, // latch or qualifier pin
  input  wire logic [7:0]  ad_i,               // multiplexed bus in
  input  wire logic        wb_cyc_i,           // wishbone cycle
  input  wire logic        wb_stb_i,           // wishbone strobe
  input  wire logic        wb_we_i,            // wishbone write
  input  wire logic [7:0]  wb_adr_i,           // wishbone byte address
  input  wire logic [3:0]  wb_sel_i,           // wishbone byte selects
  input  wire logic [31:0] wb_dat_i,           // wishbone write data
  output logic      [31:0] wb_dat_o,           // wishbone read data
  output logic             wb_ack_o,           // wishbone acknowledge
  output logic             host_int_o,         // interrupt pin to host
  output logic      [7:0]  reg_addr_o,         // captured register address
  output logic      [7:0]  reg_data_o,         // captured write data
  output logic             data_wr_o,          // pulse: data write taken
  output logic             rd_active_o         // host read in progress
);
  // pin synchronisers, two stages each
  logic [12:0] sync1_q;                        // first stage
  logic [12:0] sync2_q;                        // second stage
  logic [12:0] pins_d;                         // raw pin vector
  assign pins_d = {ad_i, addr_data_qualifier_i, strobe_b_i, strobe_a_i,
                   cs_n_i, strobe_style_select_i};
  // synchronise all pins before any logic reads them
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_q <= 13'h0e;                       // strobes high, qualifier low
      sync2_q <= 13'h0e;                       // matches idle pins, no edge
    end else if (clk_en_i) begin
      sync1_q <= pins_d;
      sync2_q <= sync1_q;
    end
  end
  // phase strap needs its own synchroniser
  logic phase_s1_q;                            // first stage
  logic phase_s2_q;                            // second stage
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_s1_q <= 1'b0;
      phase_s2_q <= 1'b0;
    end else if (clk_en_i) begin
      phase_s1_q <= address_phase_select_i;
      phase_s2_q <= phase_s1_q;
    end
  end
  // synchronised fields
  logic       style_s;                         // strobe style strap
  logic       cs_n_s;                          // chip select
  logic       sa_s;                            // first strobe
  logic       sb_s;                            // second strobe
  logic       qual_s;                          // latch or qualifier
  logic [7:0] ad_s;                            // bus value
  assign {ad_s, qual_s, sb_s, sa_s, cs_n_s, style_s} = sync2_q;

  // strap capture, once after reset release
  logic [1:0] wait_q;                          // capture delay count
  logic       strap_done_q;                    // straps captured
  logic       style_q;                         // 1: separate rd/wr strobes
  logic       phase_q;                         // 1: qualifier addressing
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_q       <= 2'h0;
      strap_done_q <= 1'b0;
      style_q      <= 1'b0;
      phase_q      <= 1'b0;
    end else if (clk_en_i && !strap_done_q) begin
      if (wait_q == host_port_pkg::STRAP_WAIT) begin
        style_q      <= style_s;
        phase_q      <= phase_s2_q;
        strap_done_q <= 1'b1;                  // frozen afterwards
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end

  // decode strobe roles from the captured style
  logic wr_strobe;                             // write strobe asserted
  logic rd_strobe;                             // read strobe asserted
  always_comb begin
    if (style_q) begin                         // separate strobes
      wr_strobe = !cs_n_s && !sb_s;
      rd_strobe = !cs_n_s && !sa_s;
    end else begin                             // direction plus data strobe
      wr_strobe = !cs_n_s && !sb_s && !sa_s;
      rd_strobe = !cs_n_s && !sb_s && sa_s;
    end
  end

  // previous values for edge detection
  logic wr_prev_q;                             // write strobe last cycle
  logic qual_prev_q;                           // qualifier last cycle
  logic qual_at_wr_q;                          // qualifier during write
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_prev_q    <= 1'b0;
      qual_prev_q  <= 1'b0;
      qual_at_wr_q <= 1'b0;
    end else if (clk_en_i) begin
      wr_prev_q   <= wr_strobe;
      qual_prev_q <= qual_s;
      if (wr_strobe) begin
        qual_at_wr_q <= qual_s;                // last level before release
      end
    end
  end
  logic wr_end;                                // write strobe released
  logic ale_fall;                              // latch strobe falling
  assign wr_end   = strap_done_q && wr_prev_q && !wr_strobe;
  assign ale_fall = strap_done_q && !phase_q && qual_prev_q && !qual_s;

  // address and data capture
  logic aval_q;                                // address seen
  logic dval_q;                                // data seen
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_addr_o <= host_port_pkg::BYTE_RST;
      reg_data_o <= host_port_pkg::BYTE_RST;
      data_wr_o  <= 1'b0;
      aval_q     <= 1'b0;
      dval_q     <= 1'b0;
    end else if (clk_en_i) begin
      data_wr_o <= 1'b0;
      if (ale_fall) begin                      // latch mode
        reg_addr_o <= ad_s;
        aval_q     <= 1'b1;
      end else if (wr_end && phase_q && qual_at_wr_q) begin
        reg_addr_o <= ad_s;                    // qualifier one
        aval_q     <= 1'b1;
      end else if (wr_end) begin
        reg_data_o <= ad_s;                    // data phase
        data_wr_o  <= 1'b1;
        dval_q     <= 1'b1;
      end
    end
  end

  // read activity flag for the data path
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_active_o <= 1'b0;
    end else if (clk_en_i) begin
      rd_active_o <= strap_done_q && rd_strobe;
    end
  end

  // wishbone slave: one wait state, ack drops after one cycle
  logic [1:0] ctrl_q;                          // {edge mode, polarity}
  logic       req_q;                           // software event pulse
  logic       ack_req_q;                       // software level release
  logic       wb_hit;                          // new access
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0;
      ctrl_q    <= host_port_pkg::CTRL_RST;
      req_q     <= 1'b0;
      ack_req_q <= 1'b0;
    end else if (clk_en_i) begin
      wb_ack_o  <= wb_hit;
      req_q     <= 1'b0;
      ack_req_q <= 1'b0;
      wb_dat_o  <= 32'h0;
      if (wb_hit && wb_we_i && wb_sel_i[0] &&
          wb_adr_i == host_port_pkg::REG_CTRL) begin
        ctrl_q    <= {wb_dat_i[host_port_pkg::CTRL_EDGE_BIT],
                      wb_dat_i[host_port_pkg::CTRL_POL_BIT]};
        req_q     <= wb_dat_i[host_port_pkg::CTRL_REQ_BIT];
        ack_req_q <= wb_dat_i[host_port_pkg::CTRL_ACK_BIT];
      end
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i)                        // unmapped reads as zero
          host_port_pkg::REG_CTRL:   wb_dat_o <= {30'h0, ctrl_q};
          host_port_pkg::REG_STATUS: wb_dat_o <= {16'h0, reg_addr_o,
                                      4'h0, dval_q, aval_q, phase_q,
                                      style_q};
          host_port_pkg::REG_WDATA:  wb_dat_o <= {24'h0, reg_data_o};
          default:                   wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // interrupt: held level or fixed width pulse, programmable polarity
  logic       int_lvl_q;                       // logical interrupt state
  logic [1:0] pulse_q;                         // pulse cycles remaining
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      int_lvl_q  <= 1'b0;
      pulse_q    <= 2'h0;
      host_int_o <= 1'b0;
    end else if (clk_en_i) begin
      if (ctrl_q[1]) begin                     // pulse mode
        int_lvl_q <= 1'b0;
        if (req_q) begin
          pulse_q <= host_port_pkg::PULSE_LEN;
        end else if (pulse_q != 2'h0) begin
          pulse_q <= pulse_q - 2'h1;
        end
      end else begin                           // held level
        pulse_q <= 2'h0;
        if (req_q) begin
          int_lvl_q <= 1'b1;                   // set wins over clear
        end else if (ack_req_q) begin
          int_lvl_q <= 1'b0;
        end
      end
      host_int_o <= ((ctrl_q[1] ? (pulse_q != 2'h0) : int_lvl_q)
                     == ctrl_q[0]) ? 1'b1 : 1'b0; // polarity
    end
  end

  // assertions
  AST_DATA_CAPTURE: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    clk_en_i && wr_end && !ale_fall && !(phase_q && qual_at_wr_q)
      |=> data_wr_o && reg_data_o == $past(ad_s))
    else $error("data not captured at write end");
  AST_ADDR_QUAL: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    clk_en_i && wr_end && phase_q && qual_at_wr_q && !ale_fall
      |=> !data_wr_o && reg_addr_o == $past(ad_s))
    else $error("qualified address not captured");
  AST_ALE_LATCH: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    clk_en_i && ale_fall |=> reg_addr_o == $past(ad_s))
    else $error("latch strobe did not capture address");
  AST_STRAP_HOLD: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    strap_done_q |=> $stable(style_q) && $stable(phase_q))
    else $error("strap value changed after capture");
  AST_STRAP_TIME: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    clk_en_i && !strap_done_q && wait_q == host_port_pkg::STRAP_WAIT
      |=> strap_done_q && phase_q == $past(phase_s2_q))
    else $error("strap not captured on time");
  AST_WR_ROLE: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    clk_en_i && strap_done_q && !style_q && !cs_n_s && !sb_s && sa_s
      |=> rd_active_o && !wr_prev_q)
    else $error("data strobe with read direction not a read");
  AST_RD_ROLE: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    clk_en_i && strap_done_q && style_q && !cs_n_s && !sa_s
      |=> rd_active_o)
    else $error("read strobe not decoded");
  AST_INT_LEVEL: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    clk_en_i && req_q && !ctrl_q[1] ##1 clk_en_i && $stable(ctrl_q)
      |=> host_int_o == ctrl_q[0])
    else $error("held interrupt not asserted");
  AST_INT_IDLE: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    clk_en_i && !int_lvl_q && pulse_q == 2'h0 && $stable(ctrl_q)
      |=> host_int_o == !$past(ctrl_q[0]))
    else $error("idle interrupt level wrong");
  COV_DATA: cover property (@(posedge clk_sys_i) data_wr_o);
  COV_ALE: cover property (@(posedge clk_sys_i) ale_fall);
  COV_PULSE: cover property (@(posedge clk_sys_i) pulse_q != 2'h0);
endmodule

// ---- verification/host_cpu_model.sv ----
// host processor model driving the parallel strobe pins
`timescale 1ns/1ns
module host_cpu_model (
  input  wire logic       clk_sys_i,  // bench clock
  output logic            cs_n_o,     // chip select, active low
  output logic            strobe_a_o, // direction or read strobe
  output logic            strobe_b_o, // data or write strobe
  output logic            qual_o,     // latch strobe or qualifier
  output logic [7:0]      ad_o        // multiplexed bus
);
  // idle pins at time zero
  initial begin
    cs_n_o = 1'b1;
    strobe_a_o = 1'b1;
    strobe_b_o = 1'b1;
    qual_o = 1'b0; // held low when idle
    ad_o = 8'h00;
  end
  // wait a number of edges
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // address phase with latch strobe
  task automatic latch_addr(input logic [7:0] val);
    ad_o <= val;
    qual_o <= 1'b1;
    tick(4);
    qual_o <= 1'b0; // falling edge latches bus
    tick(4);
    ad_o <= ~val; // released bus shows no stale value
    tick(2);
  endtask
  // one write: direction low in style 0, read strobe idle in style 1
  task automatic write_cyc(input logic style, input logic q,
                           input logic [7:0] val);
    cs_n_o <= 1'b0;
    strobe_a_o <= style;
    qual_o <= q; // address or data
    ad_o <= val;
    strobe_b_o <= 1'b0;
    tick(4);
    strobe_b_o <= 1'b1; // rising edge ends write
    tick(4);
    cs_n_o <= 1'b1;
    strobe_a_o <= 1'b1;
    qual_o <= 1'b0;
    ad_o <= ~val;
    tick(4);
  endtask
  // start a read and leave it pending
  task automatic read_start(input logic style);
    cs_n_o <= 1'b0;
    strobe_a_o <= ~style;
    strobe_b_o <= style;
    tick(5);
  endtask
  // end a read
  task automatic read_end();
    cs_n_o <= 1'b1;
    strobe_a_o <= 1'b1;
    strobe_b_o <= 1'b1;
    tick(5);
  endtask
endmodule

// ---- verification/host_bus_strobe_address_decode_tb_top.sv ----
// self-checking bench for the host port strobe and address decode
`timescale 1ns/1ns
module host_bus_strobe_address_decode_tb_top;
  logic        clk_sys_i = 1'b0;  // system clock
  logic        arst_n_i  = 1'b0;  // reset, active low
  logic        style_q   = 1'b0;  // strobe style strap
  logic        phase_q   = 1'b0;  // address phase strap
  logic        cyc_q     = 1'b0;  // wishbone cycle
  logic        stb_q     = 1'b0;  // wishbone strobe
  logic        we_q      = 1'b0;  // wishbone write
  logic [7:0]  adr_q     = 8'h00; // wishbone address
  logic [31:0] dat_q     = 32'h0; // wishbone write data
  logic [3:0]  sel_q     = 4'hf;  // wishbone byte selects
  logic        en_q      = 1'b1;  // clock enable
  int          wr_seen   = 0;     // data capture pulses seen
  logic        cs_n, sa, sb, qual; // host pins
  logic [7:0]  ad, reg_addr, reg_data; // bus and captures
  logic [31:0] rdat;              // wishbone read data
  logic        ack, host_int, data_wr, rd_active; // outputs
  int          errors    = 0;     // mismatches
  int          tests_run = 0;     // comparisons
  always #5 clk_sys_i = ~clk_sys_i;
  host_cpu_model u_host_cpu_model (.clk_sys_i(clk_sys_i), .cs_n_o(cs_n),
    .strobe_a_o(sa), .strobe_b_o(sb), .qual_o(qual), .ad_o(ad));
  host_bus_strobe_address_decode u_host_bus_strobe_address_decode (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .clk_en_i(en_q),
    .strobe_style_select_i(style_q), .address_phase_select_i(phase_q),
    .cs_n_i(cs_n), .strobe_a_i(sa), .strobe_b_i(sb),
    .addr_data_qualifier_i(qual), .ad_i(ad), .wb_cyc_i(cyc_q),
    .wb_stb_i(stb_q), .wb_we_i(we_q), .wb_adr_i(adr_q), .wb_sel_i(sel_q),
    .wb_dat_i(dat_q), .wb_dat_o(rdat), .wb_ack_o(ack),
    .host_int_o(host_int), .reg_addr_o(reg_addr), .reg_data_o(reg_data),
    .data_wr_o(data_wr), .rd_active_o(rd_active));
  // count data capture pulses, one per data write
  always @(posedge clk_sys_i) begin
    if (data_wr === 1'b1)
      wr_seen++;
  end
  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // compare one value
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic wishbone cycle, waits for ack with a bound
  task automatic xfer(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    cyc_q <= 1'b1;
    stb_q <= 1'b1;
    we_q <= we;
    adr_q <= a;
    dat_q <= d;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50) begin
      errors++;
      finish_test();
    end else begin
      cyc_q <= 1'b0;
      stb_q <= 1'b0;
    end
  endtask
  task automatic wb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic wb_rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask
  // reset with given straps, then move straps away
  task automatic do_reset(input logic s, input logic p);
    arst_n_i <= 1'b0;
    style_q <= s;
    phase_q <= p;
    repeat (4) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    style_q <= ~s;
    phase_q <= ~p;
    repeat (2) @(posedge clk_sys_i);
  endtask
  // main sequence
  initial begin
    int n;
    do_reset(1'b1, 1'b1);
    wb_rd(host_port_pkg::REG_STATUS, 32'h3);
    u_host_cpu_model.write_cyc(1'b1, 1'b1, 8'h5a);
    check(32'(reg_addr), 32'h5a);
    check(32'(wr_seen), 32'h0);
    u_host_cpu_model.write_cyc(1'b1, 1'b0, 8'ha5);
    check(32'(reg_data), 32'ha5);
    check(32'(wr_seen), 32'h1);
    wb_rd(host_port_pkg::REG_STATUS, 32'h5a0f);
    wb_rd(host_port_pkg::REG_WDATA, 32'ha5);
    u_host_cpu_model.read_start(1'b1);
    check(32'(rd_active), 32'h1);
    u_host_cpu_model.read_end();
    do_reset(1'b0, 1'b0);
    wb_rd(host_port_pkg::REG_STATUS, 32'h0);
    u_host_cpu_model.latch_addr(8'h3c);
    check(32'(reg_addr), 32'h3c);
    u_host_cpu_model.write_cyc(1'b0, 1'b0, 8'hc3);
    check(32'(reg_data), 32'hc3);
    check(32'(wr_seen), 32'h2);
    check(32'(rd_active), 32'h0);
    wb_rd(host_port_pkg::REG_STATUS, 32'h3c0c);
    en_q <= 1'b0;
    u_host_cpu_model.write_cyc(1'b0, 1'b0, 8'h77);
    en_q <= 1'b1;
    check(32'(reg_data), 32'hc3);
    check(32'(wr_seen), 32'h2);
    u_host_cpu_model.read_start(1'b0);
    check(32'(rd_active), 32'h1);
    u_host_cpu_model.read_end();
    wb_rd(host_port_pkg::REG_CTRL, 32'h0);
    wb_rd(8'h40, 32'h0);
    check(32'(host_int), 32'h1);
    wb_wr(host_port_pkg::REG_CTRL, 32'h4);
    repeat (4) @(posedge clk_sys_i);
    check(32'(host_int), 32'h0);
    wb_wr(host_port_pkg::REG_CTRL, 32'h9);
    repeat (4) @(posedge clk_sys_i);
    check(32'(host_int), 32'h0);
    wb_wr(host_port_pkg::REG_CTRL, 32'h5);
    repeat (6) @(posedge clk_sys_i);
    check(32'(host_int), 32'h1);
    wb_wr(host_port_pkg::REG_CTRL, 32'hb);
    repeat (4) @(posedge clk_sys_i);
    check(32'(host_int), 32'h0);
    wb_wr(host_port_pkg::REG_CTRL, 32'h7);
    n = 0;
    repeat (8) begin
      @(posedge clk_sys_i);
      if (host_int === 1'b1)
        n++;
    end
    check(32'(n), 32'h2);
    sel_q <= 4'h0;
    wb_wr(host_port_pkg::REG_CTRL, 32'h0);
    sel_q <= 4'hf;
    wb_rd(host_port_pkg::REG_CTRL, 32'h3);
    finish_test();
  end
endmodule
